// *** occ_pkg.sv ***
/*
  Shared constants, types and checks for the oscillator and synthesizer clock control.
  Assumes a single 20 MHz system clock that models every clock source as a level.
*/
package occ_pkg;

  // System clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Oscillator: nominal frequency, and the settling hold-off after enable
  localparam int unsigned OSC_NOMINAL_MHZ = 50;
  localparam int unsigned OSC_SETTLE_NS = 1000;
  localparam int unsigned OSC_SETTLE_CYC_I = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_CNT_W = 8;
  localparam logic [OSC_CNT_W-1:0] OSC_SETTLE_CYC = OSC_SETTLE_CYC_I[OSC_CNT_W-1:0];

  // Synthesizer divider widths and legal ranges
  localparam int unsigned REFDIV_W = 6;
  localparam int unsigned FBDIV_W = 12;
  localparam int unsigned POSTDIV_W = 3;
  localparam logic [REFDIV_W-1:0] REFDIV_MIN = 6'h01;
  localparam logic [REFDIV_W-1:0] REFDIV_MAX = 6'h3f;
  localparam logic [FBDIV_W-1:0] FBDIV_MIN = 12'h010;
  localparam logic [FBDIV_W-1:0] FBDIV_MAX = 12'h190;
  localparam logic [POSTDIV_W-1:0] POSTDIV_MIN = 3'h1;
  localparam logic [POSTDIV_W-1:0] POSTDIV_MAX = 3'h7;

  // Lock qualification: consecutive phase detector cycles without a slip
  localparam int unsigned LOCK_CNT_W = 9;
  localparam logic [LOCK_CNT_W-1:0] LOCK_CYCLES = 9'h100;

  // Divider product and phase accumulator widths
  localparam int unsigned DENOM_W = 12;
  localparam int unsigned ACC_W = 13;

  // Reset values
  localparam logic [REFDIV_W-1:0] REFDIV_RST = 6'h01;
  localparam logic [FBDIV_W-1:0] FBDIV_RST = 12'h010;
  localparam logic [POSTDIV_W-1:0] POSTDIV_RST = 3'h1;

  // Source of the two fabric clock domains
  typedef enum logic [1:0] {
    OCC_SRC_OSC,
    OCC_SRC_SYNTH,
    OCC_SRC_EXT,
    OCC_SRC_NONE
  } occ_src_t;

  // Whole divider setting is legal, including the post divider ordering
  function automatic logic occ_cfg_valid(input logic [REFDIV_W-1:0] refdiv,
                                         input logic [FBDIV_W-1:0] fbdiv,
                                         input logic [POSTDIV_W-1:0] div_a,
                                         input logic [POSTDIV_W-1:0] div_b);
    logic ok;
    ok = (refdiv >= REFDIV_MIN) && (refdiv <= REFDIV_MAX);
    ok = ok && (fbdiv >= FBDIV_MIN) && (fbdiv <= FBDIV_MAX);
    ok = ok && (div_a >= POSTDIV_MIN) && (div_a <= POSTDIV_MAX);
    ok = ok && (div_b >= POSTDIV_MIN) && (div_b <= POSTDIV_MAX);
    ok = ok && !((div_a == POSTDIV_MIN) && (div_b > POSTDIV_MIN));
    return ok;
  endfunction

endpackage

// *** occ_if.sv ***
/*
  Interface joining the clock control device end and the fabric user logic end.
  Assumes both ends run on the same system clock; the testbench instantiates it.
*/
`timescale 1ns/1ps
interface occ_if;
  import occ_pkg::*;

  logic oscillator_power_on;
  logic internal_oscillator_clock;
  logic oscillator_stable;
  logic synth_power_on;
  logic synth_ref_select;
  logic synth_bypass;
  logic [REFDIV_W-1:0] synth_ref_divider;
  logic [FBDIV_W-1:0] synth_feedback_divider;
  logic [POSTDIV_W-1:0] synth_output_divider_a;
  logic [POSTDIV_W-1:0] synth_output_divider_b;
  logic synth_clock;
  logic synth_lock;
  occ_src_t fabric_src_select;
  logic fabric_clock_a;
  logic fabric_clock_b;

  modport device (
    input oscillator_power_on, synth_power_on, synth_ref_select, synth_bypass,
    input synth_ref_divider, synth_feedback_divider,
    input synth_output_divider_a, synth_output_divider_b, fabric_src_select,
    output internal_oscillator_clock, oscillator_stable, synth_clock, synth_lock,
    output fabric_clock_a, fabric_clock_b
  );

  modport user (
    output oscillator_power_on, synth_power_on, synth_ref_select, synth_bypass,
    output synth_ref_divider, synth_feedback_divider,
    output synth_output_divider_a, synth_output_divider_b, fabric_src_select,
    input internal_oscillator_clock, oscillator_stable, synth_clock, synth_lock,
    input fabric_clock_a, fabric_clock_b
  );
endinterface

// *** occ_device.sv ***
/*
  Device end: oscillator with settling hold-off, frequency synthesizer with
  reference select, bypass, dividers and lock qualification, and two fabric clock domains.
  Assumes the user end drives the controls from the same system clock; the external
  reference arrives asynchronously on a pin. Clocks are modelled as levels sampled on clk_i,
  so modelled frequencies are bounded by the system clock rate.
*/
// Contract
// - Provide nominal 50 MHz oscillator clock to core; the model toggles it on every clk_i, i.e. 10 MHz
// - Oscillator runs only while enable is high
// - Hold back oscillator clock during settling delay
// - Stable output goes high once settled
// - Oscillator feeds core network or synthesizer reference
// - Reference select low oscillator, high external pin
// - Bypass passes reference straight to synthesizer output
// - User drives reference divider 1 to 63
// - User drives feedback divider 16 to 400
// - Post dividers 1 to 7, divide by product
// - First post divider one with second above rejected
// - Output equals reference times feedback over divisors
// - Internal stage and phase detector frequency formulas
// - Synthesizer powered only while power-on high
// - Lock after 256 slip-free phase detector cycles
// - Synthesizer clock qualified by lock state
// - User waits for lock before trusting clock
// - Two core clock domains from both edges
`timescale 1ns/1ps
module occ_device
  import occ_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // External reference pin
  input wire logic external_reference_clock_i,
  // Link to user logic
  occ_if.device link
);

  // Oscillator state
  logic [OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
  logic osc_phase_q, osc_phase_d;
  logic osc_stable_q, osc_stable_d;
  logic osc_out_q, osc_out_d;

  // External reference synchroniser and edge detect
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_edge;

  // Synthesizer state
  logic [REFDIV_W-1:0] cfg_ref_q;
  logic [FBDIV_W-1:0] cfg_fb_q;
  logic [POSTDIV_W-1:0] cfg_a_q, cfg_b_q;
  logic cfg_sel_q;
  logic [REFDIV_W-1:0] pfd_cnt_q, pfd_cnt_d;
  logic [LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;
  logic lock_q, lock_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic vco_phase_q, vco_phase_d;
  logic synth_clk_q, synth_clk_d;

  // Fabric clocks
  logic fab_a_q, fab_a_d;
  logic fab_b_q, fab_b_d;

  logic osc_tick;
  logic ref_tick;
  logic ref_level;
  logic cfg_ok;
  logic cfg_changed;
  logic synth_hold;
  logic pfd_tick;
  logic [DENOM_W-1:0] denom;

  // Oscillator runs only while enabled; output held off until settled
  always_comb begin
    osc_cnt_d = osc_cnt_q;
    osc_stable_d = osc_stable_q;
    osc_phase_d = 1'b0;
    if (!link.oscillator_power_on) begin
      osc_cnt_d = '0;
      osc_stable_d = 1'b0;
    end else begin
      osc_phase_d = ~osc_phase_q;
      if (osc_cnt_q < OSC_SETTLE_CYC) begin
        osc_cnt_d = osc_cnt_q + 1'b1;
      end else begin
        osc_stable_d = 1'b1;
      end
    end
    // Gating by the stable flag keeps partial pulses off the output
    osc_out_d = osc_phase_d & osc_stable_d;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_cnt_q <= '0;
      osc_phase_q <= 1'b0;
      osc_stable_q <= 1'b0;
      osc_out_q <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      osc_phase_q <= osc_phase_d;
      osc_stable_q <= osc_stable_d;
      osc_out_q <= osc_out_d;
    end
  end

  // Pin is asynchronous: two flops before the edge detector looks at it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_reference_clock_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_edge = ext_s2_q & ~ext_s3_q;
  // Oscillator reference taken before the hold-off gate, as the synthesizer has its own lock
  assign osc_tick = link.oscillator_power_on & ~osc_phase_q;
  assign ref_tick = link.synth_ref_select ? ext_edge : osc_tick;
  assign ref_level = link.synth_ref_select ? ext_s2_q : osc_phase_q;

  assign cfg_ok = occ_cfg_valid(link.synth_ref_divider, link.synth_feedback_divider,
                                link.synth_output_divider_a,
                                link.synth_output_divider_b);
  assign cfg_changed = (cfg_ref_q != link.synth_ref_divider) ||
                       (cfg_fb_q != link.synth_feedback_divider) ||
                       (cfg_a_q != link.synth_output_divider_a) ||
                       (cfg_b_q != link.synth_output_divider_b) ||
                       (cfg_sel_q != link.synth_ref_select);
  assign synth_hold = !link.synth_power_on || cfg_changed || !cfg_ok;
  assign denom = DENOM_W'(cfg_ref_q) * DENOM_W'(cfg_a_q) * DENOM_W'(cfg_b_q);

  // Phase detector ticks once per reference divider count of reference edges
  assign pfd_tick = ref_tick && ((pfd_cnt_q + 1'b1) >= cfg_ref_q);

  always_comb begin
    pfd_cnt_d = pfd_cnt_q;
    lock_cnt_d = lock_cnt_q;
    lock_d = lock_q;
    acc_d = acc_q;
    vco_phase_d = vco_phase_q;
    if (synth_hold) begin
      pfd_cnt_d = '0;
      lock_cnt_d = '0;
      lock_d = 1'b0;
      acc_d = '0;
      vco_phase_d = 1'b0;
    end else begin
      if (ref_tick) begin
        pfd_cnt_d = pfd_tick ? '0 : pfd_cnt_q + 1'b1;
      end
      if (pfd_tick && (lock_cnt_q < LOCK_CYCLES)) begin
        lock_cnt_d = lock_cnt_q + 1'b1;
      end
      lock_d = (lock_cnt_q >= LOCK_CYCLES);
      // Twice the feedback per reference edge, as one output period is two toggles
      acc_d = acc_q + (ref_tick ? ACC_W'({cfg_fb_q, 1'b0}) : '0);
      if (acc_d >= ACC_W'(denom)) begin
        acc_d = acc_d - ACC_W'(denom);
        vco_phase_d = ~vco_phase_q;
      end
    end
    if (link.synth_bypass) begin
      synth_clk_d = ref_level;
    end else begin
      synth_clk_d = vco_phase_d & lock_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_ref_q <= REFDIV_RST;
      cfg_fb_q <= FBDIV_RST;
      cfg_a_q <= POSTDIV_RST;
      cfg_b_q <= POSTDIV_RST;
      cfg_sel_q <= 1'b0;
      pfd_cnt_q <= '0;
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
      acc_q <= '0;
      vco_phase_q <= 1'b0;
      synth_clk_q <= 1'b0;
    end else begin
      cfg_ref_q <= link.synth_ref_divider;
      cfg_fb_q <= link.synth_feedback_divider;
      cfg_a_q <= link.synth_output_divider_a;
      cfg_b_q <= link.synth_output_divider_b;
      cfg_sel_q <= link.synth_ref_select;
      pfd_cnt_q <= pfd_cnt_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q <= lock_d;
      acc_q <= acc_d;
      vco_phase_q <= vco_phase_d;
      synth_clk_q <= synth_clk_d;
    end
  end

  // Domain b is the inverted source, i.e. the falling-edge domain
  always_comb begin
    case (link.fabric_src_select)
      OCC_SRC_OSC: fab_a_d = osc_out_d;
      OCC_SRC_SYNTH: fab_a_d = synth_clk_d;
      OCC_SRC_EXT: fab_a_d = ext_s2_q;
      default: fab_a_d = 1'b0;
    endcase
    fab_b_d = (link.fabric_src_select == OCC_SRC_NONE) ? 1'b0 : ~fab_a_d;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fab_a_q <= 1'b0;
      fab_b_q <= 1'b0;
    end else begin
      fab_a_q <= fab_a_d;
      fab_b_q <= fab_b_d;
    end
  end

  assign link.internal_oscillator_clock = osc_out_q;
  assign link.oscillator_stable = osc_stable_q;
  assign link.synth_clock = synth_clk_q;
  assign link.synth_lock = lock_q;
  assign link.fabric_clock_a = fab_a_q;
  assign link.fabric_clock_b = fab_b_q;

endmodule // occ_device

// *** occ_user.sv ***
/*
  User end: fabric logic that takes clock settings from its own ports, refuses
  illegal divider settings, and waits for lock, unless bypassed, before selecting the synthesizer clock.
  Assumes the device end shares clk_i, so its status needs no synchroniser.
*/
`timescale 1ns/1ps
module occ_user
  import occ_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Requested settings, taken on apply_i
  input wire logic apply_i,
  input wire logic osc_on_i,
  input wire logic synth_on_i,
  input wire logic ref_sel_i,
  input wire logic bypass_i,
  input wire logic [REFDIV_W-1:0] ref_div_i,
  input wire logic [FBDIV_W-1:0] fb_div_i,
  input wire logic [POSTDIV_W-1:0] div_a_i,
  input wire logic [POSTDIV_W-1:0] div_b_i,
  input wire occ_src_t fabric_src_i,
  // Status
  output logic cfg_rejected_o,
  output logic osc_settled_o,
  output logic synth_ready_o,
  output logic fabric_clk_a_o,
  output logic fabric_clk_b_o,
  // Link to the device
  occ_if.user link
);

  logic osc_on_q, osc_on_d;
  logic synth_on_q, synth_on_d;
  logic sel_q, sel_d;
  logic byp_q, byp_d;
  logic [REFDIV_W-1:0] ref_q, ref_d;
  logic [FBDIV_W-1:0] fb_q, fb_d;
  logic [POSTDIV_W-1:0] a_q, a_d;
  logic [POSTDIV_W-1:0] b_q, b_d;
  occ_src_t src_q, src_d;
  logic rej_q, rej_d;
  logic osc_rdy_q, osc_rdy_d;
  logic syn_rdy_q, syn_rdy_d;
  logic fa_q, fb_clk_q;

  always_comb begin
    osc_on_d = osc_on_q;
    synth_on_d = synth_on_q;
    sel_d = sel_q;
    byp_d = byp_q;
    ref_d = ref_q;
    fb_d = fb_q;
    a_d = a_q;
    b_d = b_q;
    src_d = src_q;
    rej_d = rej_q;
    if (apply_i) begin
      osc_on_d = osc_on_i;
      synth_on_d = synth_on_i;
      sel_d = ref_sel_i;
      byp_d = bypass_i;
      src_d = fabric_src_i;
      // Illegal divider sets keep the last legal one so the device never sees them
      if (occ_cfg_valid(ref_div_i, fb_div_i, div_a_i, div_b_i)) begin
        ref_d = ref_div_i;
        fb_d = fb_div_i;
        a_d = div_a_i;
        b_d = div_b_i;
        rej_d = 1'b0;
      end else begin
        rej_d = 1'b1;
      end
    end
    osc_rdy_d = link.oscillator_stable;
    syn_rdy_d = link.synth_lock & synth_on_q;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_on_q <= 1'b0;
      synth_on_q <= 1'b0;
      sel_q <= 1'b0;
      byp_q <= 1'b0;
      ref_q <= REFDIV_RST;
      fb_q <= FBDIV_RST;
      a_q <= POSTDIV_RST;
      b_q <= POSTDIV_RST;
      src_q <= OCC_SRC_NONE;
      rej_q <= 1'b0;
      osc_rdy_q <= 1'b0;
      syn_rdy_q <= 1'b0;
      fa_q <= 1'b0;
      fb_clk_q <= 1'b0;
    end else begin
      osc_on_q <= osc_on_d;
      synth_on_q <= synth_on_d;
      sel_q <= sel_d;
      byp_q <= byp_d;
      ref_q <= ref_d;
      fb_q <= fb_d;
      a_q <= a_d;
      b_q <= b_d;
      src_q <= src_d;
      rej_q <= rej_d;
      osc_rdy_q <= osc_rdy_d;
      syn_rdy_q <= syn_rdy_d;
      fa_q <= link.fabric_clock_a;
      fb_clk_q <= link.fabric_clock_b;
    end
  end

  assign link.oscillator_power_on = osc_on_q;
  assign link.synth_power_on = synth_on_q;
  assign link.synth_ref_select = sel_q;
  assign link.synth_bypass = byp_q;
  assign link.synth_ref_divider = ref_q;
  assign link.synth_feedback_divider = fb_q;
  assign link.synth_output_divider_a = a_q;
  assign link.synth_output_divider_b = b_q;
  // Synthesizer source only once locked (or bypassed); fall back to no clock meanwhile
  assign link.fabric_src_select = ((src_q == OCC_SRC_SYNTH) && !link.synth_lock && !byp_q) ?
                                  OCC_SRC_NONE : src_q;

  assign cfg_rejected_o = rej_q;
  assign osc_settled_o = osc_rdy_q;
  assign synth_ready_o = syn_rdy_q;
  assign fabric_clk_a_o = fa_q;
  assign fabric_clk_b_o = fb_clk_q;

endmodule // occ_user

// *** occ_chk.sv ***
/*
  Concurrent checks on the link between the clock control device end and the user end.
  Assumes one system clock and a synchronous active-high reset; placed beside the link.
*/
`timescale 1ns/1ps
module occ_chk
  import occ_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link signals
  input wire logic oscillator_power_on,
  input wire logic internal_oscillator_clock,
  input wire logic oscillator_stable,
  input wire logic synth_power_on,
  input wire logic synth_ref_select,
  input wire logic synth_bypass,
  input wire logic [REFDIV_W-1:0] synth_ref_divider,
  input wire logic [FBDIV_W-1:0] synth_feedback_divider,
  input wire logic [POSTDIV_W-1:0] synth_output_divider_a,
  input wire logic [POSTDIV_W-1:0] synth_output_divider_b,
  input wire logic synth_clock,
  input wire logic synth_lock,
  input wire occ_src_t fabric_src_select,
  input wire logic fabric_clock_a,
  input wire logic fabric_clock_b
);
  logic [7:0] en_cnt_q;
  logic [7:0] en_cnt_d;
  logic [15:0] run_cnt_q;
  logic [15:0] run_cnt_d;
  logic [24:0] cfg_q;
  logic [24:0] cfg_d;

  // Cycles with the oscillator enabled, and with the synthesizer on and its settings unchanged
  always_comb begin
    cfg_d = {synth_ref_select, synth_ref_divider, synth_feedback_divider,
             synth_output_divider_a, synth_output_divider_b};
    en_cnt_d = !oscillator_power_on ? 8'h00 : en_cnt_q + {7'h00, en_cnt_q != 8'hff};
    run_cnt_d = (!synth_power_on || cfg_d != cfg_q) ? 16'h0000 : run_cnt_q + 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    cfg_q <= cfg_d;
    if (sys_rst_i) begin
      en_cnt_q <= 8'h00;
      run_cnt_q <= 16'h0000;
    end else begin
      en_cnt_q <= en_cnt_d;
      run_cnt_q <= run_cnt_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_settle_min;
    oscillator_stable |-> en_cnt_q >= OSC_SETTLE_CYC;
  endproperty
  property p_settle_max;
    en_cnt_q == OSC_SETTLE_CYC + 8'h03 |-> oscillator_stable;
  endproperty
  property p_osc_gate;
    !oscillator_stable |-> !internal_oscillator_clock;
  endproperty
  property p_osc_run;
    oscillator_stable ##1 oscillator_stable |-> internal_oscillator_clock != $past(internal_oscillator_clock);
  endproperty
  property p_lock_off;
    !synth_power_on |=> !synth_lock;
  endproperty
  property p_lock_change;
    cfg_d != cfg_q |=> !synth_lock;
  endproperty
  // Reference edges arrive at most every second clock, so lock needs this many steady cycles
  property p_lock_min;
    $rose(synth_lock) |-> (run_cnt_q + 16'h0008) >= {1'b0, synth_ref_divider, 9'h000};
  endproperty
  property p_clk_qual;
    (!synth_bypass && !synth_lock) [*2] |-> !synth_clock;
  endproperty
  property p_bypass;
    (synth_bypass && synth_power_on && !synth_ref_select && oscillator_power_on) [*4]
      |-> $changed(synth_clock);
  endproperty
  property p_fab_split;
    fabric_clock_b == ($past(fabric_src_select) != OCC_SRC_NONE && !fabric_clock_a);
  endproperty
  property p_fab_src;
    $past(fabric_src_select) inside {OCC_SRC_OSC, OCC_SRC_SYNTH} |-> fabric_clock_a ==
      ($past(fabric_src_select) == OCC_SRC_OSC ? internal_oscillator_clock : synth_clock);
  endproperty

  a_settle_min: assert property (p_settle_min)
    else $error("oscillator stable before settling");
  a_settle_max: assert property (p_settle_max)
    else $error("oscillator stable late");
  a_osc_gate: assert property (p_osc_gate)
    else $error("oscillator clock not held back");
  a_osc_run: assert property (p_osc_run)
    else $error("oscillator clock not running");
  a_lock_off: assert property (p_lock_off)
    else $error("lock while powered down");
  a_lock_change: assert property (p_lock_change)
    else $error("lock kept over setting change");
  a_lock_min: assert property (p_lock_min)
    else $error("lock too early");
  a_clk_qual: assert property (p_clk_qual)
    else $error("synth clock without lock");
  a_bypass: assert property (p_bypass)
    else $error("bypass not passing reference");
  a_fab_split: assert property (p_fab_split)
    else $error("domain b not inverse of a");
  a_fab_src: assert property (p_fab_src)
    else $error("domain a not following source");

  c_settled: cover property ($rose(oscillator_stable));
  c_locked: cover property ($rose(synth_lock));
  c_bypass: cover property (synth_bypass && synth_clock);
endmodule // occ_chk

// *** tb_occ.sv ***
/*
  Self-checking bench for the device and user ends joined by the link.
  Assumes it makes the 20 MHz clock, the reset and the external reference pin itself.
*/
`timescale 1ns/1ps
module tb_occ;
  import occ_pkg::*;
  localparam int LIMIT = 10000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xref = 1'b0;
  logic xrun = 1'b0;
  logic [1:0] xcnt = 2'h0;
  logic apply = 1'b0;
  logic o_on = 1'b0;
  logic s_on = 1'b0;
  logic sel = 1'b0;
  logic byp = 1'b0;
  logic [REFDIV_W-1:0] rd = REFDIV_RST;
  logic [FBDIV_W-1:0] fb = FBDIV_RST;
  logic [POSTDIV_W-1:0] da = POSTDIV_RST;
  logic [POSTDIV_W-1:0] db = POSTDIV_RST;
  occ_src_t src = OCC_SRC_NONE;
  logic rej;
  logic ordy;
  logic srdy;
  logic fca;
  logic fcb;
  logic p;
  logic [23:0] v;
  logic [23:0] good;
  logic [23:0] tbl [9];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  occ_if i_occ_if();
  occ_device i_occ_device(.clk_i(clk), .sys_rst_i(rst), .external_reference_clock_i(xref),
    .link(i_occ_if));
  occ_user i_occ_user(.clk_i(clk), .sys_rst_i(rst), .apply_i(apply), .osc_on_i(o_on),
    .synth_on_i(s_on), .ref_sel_i(sel), .bypass_i(byp), .ref_div_i(rd), .fb_div_i(fb),
    .div_a_i(da), .div_b_i(db), .fabric_src_i(src), .cfg_rejected_o(rej), .osc_settled_o(ordy),
    .synth_ready_o(srdy), .fabric_clk_a_o(fca), .fabric_clk_b_o(fcb), .link(i_occ_if));
  occ_chk i_occ_chk(.clk_i(clk), .sys_rst_i(rst),
    .oscillator_power_on(i_occ_if.oscillator_power_on),
    .internal_oscillator_clock(i_occ_if.internal_oscillator_clock),
    .oscillator_stable(i_occ_if.oscillator_stable), .synth_power_on(i_occ_if.synth_power_on),
    .synth_ref_select(i_occ_if.synth_ref_select), .synth_bypass(i_occ_if.synth_bypass),
    .synth_ref_divider(i_occ_if.synth_ref_divider),
    .synth_feedback_divider(i_occ_if.synth_feedback_divider),
    .synth_output_divider_a(i_occ_if.synth_output_divider_a),
    .synth_output_divider_b(i_occ_if.synth_output_divider_b),
    .synth_clock(i_occ_if.synth_clock), .synth_lock(i_occ_if.synth_lock),
    .fabric_src_select(i_occ_if.fabric_src_select), .fabric_clock_a(i_occ_if.fabric_clock_a),
    .fabric_clock_b(i_occ_if.fabric_clock_b));

  always #25 clk = ~clk;

  // External reference toggles every third clock while running and stands still otherwise
  always @(posedge clk) begin
    xcnt <= (xcnt == 2'h2) ? 2'h0 : xcnt + 2'h1;
    if (xrun && xcnt == 2'h2) begin
      xref <= !xref;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      end_of_test();
    end
  end

  function automatic logic legal(input logic [23:0] s);
    return s[23:18] != 6'h00 && s[17:6] >= 12'h010 && s[17:6] <= 12'h190 && s[5:3] != 3'h0
      && s[2:0] != 3'h0 && !(s[5:3] == 3'h1 && s[2:0] > 3'h1);
  endfunction

  function automatic int exp_lock(input int r, input int per);
    return 256 * r * per;
  endfunction

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg(input logic o, input logic s, input logic r, input logic b,
                     input logic [23:0] d, input occ_src_t sr);
    @(posedge clk);
    #2;
    {o_on, s_on, sel, byp} = {o, s, r, b};
    {rd, fb, da, db} = d;
    src = sr;
    apply = 1'b1;
    @(posedge clk);
    #2;
    apply = 1'b0;
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic wait_sig(input bit lock, output int c);
    c = 0;
    do begin
      step();
      c++;
    end while ((lock ? i_occ_if.synth_lock : i_occ_if.oscillator_stable) !== 1'b1 && c < 4000);
  endtask

  task automatic count_tog(input int w, output int t);
    t = 0;
    p = i_occ_if.synth_clock;
    repeat (w) begin
      step();
      t += (i_occ_if.synth_clock !== p);
      p = i_occ_if.synth_clock;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h2d04));
    tbl = '{{6'h00, 12'h010, 3'h1, 3'h1}, {6'h01, 12'h00f, 3'h1, 3'h1},
            {6'h3f, 12'h190, 3'h7, 3'h7}, {6'h01, 12'h191, 3'h1, 3'h1},
            {6'h01, 12'h010, 3'h0, 3'h1}, {6'h01, 12'h010, 3'h2, 3'h0},
            {6'h01, 12'h010, 3'h1, 3'h4}, {6'h01, 12'h010, 3'h2, 3'h2},
            {6'h3f, 12'h010, 3'h1, 3'h1}};
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("reset outputs", {i_occ_if.oscillator_stable, i_occ_if.internal_oscillator_clock,
      i_occ_if.synth_lock, i_occ_if.synth_clock, i_occ_if.fabric_clock_a,
      i_occ_if.fabric_clock_b, rej, srdy}, 24'h00_0000);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, {6'h01, 12'h010, 3'h1, 3'h1}, OCC_SRC_OSC);
    wait_sig(1'b0, n);
    chk("settle", n >= OSC_SETTLE_CYC && n <= OSC_SETTLE_CYC + 3, 1'b1);
    p = i_occ_if.internal_oscillator_clock;
    step();
    chk("osc toggle", i_occ_if.internal_oscillator_clock, !p);
    chk("oscillator_stable", ordy, 1'b1);
    chk("domain a", i_occ_if.fabric_clock_a, i_occ_if.internal_oscillator_clock);
    chk("domain b", i_occ_if.fabric_clock_b, !i_occ_if.fabric_clock_a);
    p = i_occ_if.fabric_clock_a;
    step();
    chk("user domain a", fca, p);
    chk("user domain b", fcb, !p);
    // Oscillator reference, dividers kept off the saturating rate so the ratio shows
    cfg(1'b1, 1'b1, 1'b0, 1'b0, {6'h02, 12'h010, 3'h7, 3'h4}, OCC_SRC_SYNTH);
    wait_sig(1'b1, n);
    chk("osc lock", n + 8 >= exp_lock(2, 2) && n <= exp_lock(2, 2) + 40, 1'b1);
    count_tog(560, n);
    chk("synth rate", n + 1 >= 160 && n <= 161, 1'b1);
    chk("synth ready", srdy, 1'b1);
    chk("domain a synth", i_occ_if.fabric_clock_a, i_occ_if.synth_clock);
    cfg(1'b1, 1'b1, 1'b0, 1'b0, {6'h02, 12'h011, 3'h7, 3'h4}, OCC_SRC_SYNTH);
    step();
    chk("lock after change", i_occ_if.synth_lock, 1'b0);
    repeat (2) step();
    chk("unlocked outputs", {i_occ_if.synth_clock, i_occ_if.fabric_clock_a,
      i_occ_if.fabric_clock_b, srdy}, 24'h00_0000);
    step();
    xrun = 1'b1;
    cfg(1'b0, 1'b1, 1'b1, 1'b0, {6'h01, 12'h010, 3'h1, 3'h1}, OCC_SRC_SYNTH);
    wait_sig(1'b1, n);
    chk("ext lock", n + 8 >= exp_lock(1, 6) && n <= exp_lock(1, 6) + 40, 1'b1);
    chk("osc off", i_occ_if.oscillator_stable, 1'b0);
    cfg(1'b0, 1'b0, 1'b1, 1'b0, {6'h01, 12'h010, 3'h1, 3'h1}, OCC_SRC_EXT);
    step();
    chk("lock powered off", i_occ_if.synth_lock, 1'b0);
    cfg(1'b0, 1'b1, 1'b1, 1'b1, {6'h01, 12'h010, 3'h1, 3'h1}, OCC_SRC_SYNTH);
    count_tog(60, n);
    chk("bypass edges", n >= 18 && n <= 21, 1'b1);
    // Oscillator reference in bypass: its level flips on every clock once enabled
    cfg(1'b1, 1'b1, 1'b0, 1'b1, {6'h01, 12'h010, 3'h1, 3'h1}, OCC_SRC_SYNTH);
    count_tog(60, n);
    chk("osc bypass edges", n >= 59 && n <= 60, 1'b1);
    good = {6'h01, 12'h010, 3'h1, 3'h1};
    for (int i = 0; i < 40; i++) begin
      v = (i < 9) ? tbl[i] : {6'($urandom), 12'($urandom_range(0, 420)), 6'($urandom)};
      cfg(1'b1, 1'($urandom), 1'b0, 1'b0, v, OCC_SRC_OSC);
      step();
      chk("rejected", rej, !legal(v));
      if (legal(v)) begin
        good = v;
      end
      chk("kept setting", {i_occ_if.synth_ref_divider, i_occ_if.synth_feedback_divider,
        i_occ_if.synth_output_divider_a, i_occ_if.synth_output_divider_b}, good);
    end
    end_of_test();
  end
endmodule // tb_occ
